/* rtl/dps_pkg.sv */
// Package with constants and carrier types for the burst-of-two dual-port memory
package dps_pkg;
	localparam int ADDR_W          = 20;
	localparam int WORD_W          = 18;
	localparam int BYTE_W          = 9;
	localparam int NBYTES          = 2;
	localparam int DEPTH           = 1 << ADDR_W;
	localparam int SYS_CLK_MHZ     = 10;
	localparam int LOCK_TIME_US    = 20;
	localparam int LOCK_CYCLES     = LOCK_TIME_US * SYS_CLK_MHZ;
	localparam int LOCK_CNT_W      = 8;
	localparam int CAL_CYCLES      = 1024;
	localparam int CAL_CNT_W       = 10;
	localparam logic [NBYTES-1:0] BWS_NONE = 2'h3;
	localparam logic [WORD_W-1:0] WORD_ZERO = 18'h00000;

	typedef struct packed {
		logic [WORD_W-1:0] data;
		logic [NBYTES-1:0] bws_n;
	} dps_wr_word_t;

	typedef struct packed {
		logic [WORD_W-1:0] w1;
		logic [WORD_W-1:0] w0;
	} dps_burst_t;
endpackage : dps_pkg

/* rtl/dps_sync2.sv */
// Two-flop level synchroniser with a constant reset value
module dps_sync2 #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_reg;
	logic sync_reg;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_reg <= RESET_VAL;
			sync_reg <= RESET_VAL;
		end else begin
			meta_reg <= d_in;
			sync_reg <= meta_reg;
		end
	end

	assign q_out = sync_reg;
endmodule : dps_sync2

/* rtl/dps_imp_cal.sv */
// Periodic output impedance recalibration timer
module dps_imp_cal
	import dps_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_in,
	output logic      update_out
);
	logic [CAL_CNT_W-1:0] cnt_reg;
	logic [CAL_CNT_W-1:0] cnt_next;
	logic                 upd_reg;
	logic                 wrap;

	localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CYCLES - 1);

	assign wrap     = (cnt_reg == CAL_LAST);
	assign cnt_next = wrap ? '0 : cnt_reg + 1'b1;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_reg <= '0;
			upd_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			upd_reg <= wrap; // see [RULE_16]
		end
	end

	assign update_out = upd_reg;
endmodule : dps_imp_cal

/* rtl/dps_sram_top.sv */
// Top of the burst-of-two read/write port memory device
// Operation
// [RULE_01] Storage in two arrays; every access moves two words at one address.
// [RULE_02] PLL on gives 1.5 cycle read latency; PLL off gives one cycle.
// [RULE_03] Accesses begin only on positive input clock rises.
// [RULE_04] Selects, byte selects and write data captured on input clock rises.
// [RULE_05] Read data launched on output clock pair, or input pair in single mode.
// [RULE_06] Read select low at clock rise stores address in read address register.
// [RULE_07] Low word on negative output clock, second word on next positive rise. With the PLL off the code puts the low word on the positive rise first.
// [RULE_08] Outputs released to high impedance at the output clock rise after a burst.
// [RULE_09] Write select low captures first word with byte selects at same rise.
// [RULE_10] Negative rise brings write address and second word; both words committed.
// [RULE_11] Bytes with inactive select keep stored contents.
// [RULE_12] Deselected write port finishes pending write, then ignores inputs.
// [RULE_13] Both output clocks high at power on selects fixed single clock mode.
// [RULE_14] Concurrent read and write allowed; read returns newest data.
// [RULE_15] Selects sampled on positive rises; ports independent; pending work completes.
// [RULE_16] Output impedance recalibrated every 1024 clock cycles.
// [RULE_17] Two free-running echo clocks follow the active output clock pair.
// [RULE_18] PLL locks a fixed time after stable clock; lock is reported.
// [RULE_19] Controller may stop input clocks briefly to reset the PLL; the lock timer ignores K and restarts only when pll_off_n_in is low or rst_in is high.
// [RULE_20] Comes up deselected with read outputs in high impedance.
// [RULE_21] Controller may change byte selects between the two write words.
module dps_sram_top
	import dps_pkg::*;
(
	input  wire logic              clk_sys_in,
	input  wire logic              rst_in,
	input  wire logic              k_clk_in,
	input  wire logic              c_clk_in,
	input  wire logic              c_n_clk_in,
	input  wire logic              pll_off_n_in,
	input  wire logic              read_port_select_n_in,
	input  wire logic              write_port_select_n_in,
	input  wire logic [NBYTES-1:0] byte_write_select_n_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [WORD_W-1:0] d_in,
	output logic      [WORD_W-1:0] q_out,
	output logic                   q_oe_out,
	output logic                   echo_clock_out,
	output logic                   echo_clock_n_out,
	output logic                   pll_locked_out,
	output logic                   single_clock_mode_out,
	output logic                   impedance_update_out
);
	// Per-byte arrays so masked bytes need no read-modify-write
	logic [BYTE_W-1:0] mem_lo_b0 [DEPTH];
	logic [BYTE_W-1:0] mem_lo_b1 [DEPTH];
	logic [BYTE_W-1:0] mem_hi_b0 [DEPTH];
	logic [BYTE_W-1:0] mem_hi_b1 [DEPTH];

	// System clock domain
	logic                  c_hi_sync;
	logic                  cn_hi_sync;
	logic [1:0]            strap_age_reg;
	logic                  strap_done_reg;
	logic                  single_sys_reg;
	logic                  both_c_high;
	logic [LOCK_CNT_W-1:0] lock_cnt_reg;
	logic [LOCK_CNT_W-1:0] lock_cnt_next;
	logic                  lock_reg;
	logic                  pll_on_sys;
	logic                  lock_reached;

	// Two sync stages and the lock flop count toward the lock time
	localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_CYCLES - 3);
	// Strap synchronisers show their reset value for two edges after release
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	dps_sync2 #(.RESET_VAL(1'b0)) u_sync_c (
		.clk_in (clk_sys_in),
		.rst_in (rst_in),
		.d_in   (c_clk_in),
		.q_out  (c_hi_sync)
	);

	dps_sync2 #(.RESET_VAL(1'b0)) u_sync_cn (
		.clk_in (clk_sys_in),
		.rst_in (rst_in),
		.d_in   (c_n_clk_in),
		.q_out  (cn_hi_sync)
	);

	dps_sync2 #(.RESET_VAL(1'b0)) u_sync_pll_sys (
		.clk_in (clk_sys_in),
		.rst_in (rst_in),
		.d_in   (pll_off_n_in),
		.q_out  (pll_on_sys)
	);

	assign both_c_high   = c_hi_sync & cn_hi_sync;
	assign lock_reached  = (lock_cnt_reg == LOCK_LAST);
	assign lock_cnt_next = lock_reached ? lock_cnt_reg : lock_cnt_reg + 1'b1;

	// Strap caught once the synchronisers hold real pin levels, then frozen
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			strap_age_reg  <= 2'h0;
			strap_done_reg <= 1'b0;
			single_sys_reg <= 1'b0;
		end else if (strap_age_reg != STRAP_WAIT) begin
			strap_age_reg  <= strap_age_reg + 2'h1;
		end else if (!strap_done_reg) begin
			strap_done_reg <= 1'b1;
			single_sys_reg <= both_c_high; // see [RULE_13]
		end
	end

	// Lock timer only runs with the PLL enabled; restarts if it is turned off
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			lock_cnt_reg <= '0;
			lock_reg     <= 1'b0;
		end else if (!pll_on_sys) begin
			lock_cnt_reg <= '0;
			lock_reg     <= 1'b0;
		end else begin
			lock_cnt_reg <= lock_cnt_next; // see [RULE_18]
			lock_reg     <= lock_reached;
		end
	end

	dps_imp_cal u_imp_cal (
		.clk_in     (clk_sys_in),
		.rst_in     (rst_in),
		.update_out (impedance_update_out)
	);

	assign pll_locked_out        = lock_reg;
	assign single_clock_mode_out = single_sys_reg;

	// Input clock domain
	logic         rst_k;
	logic         pll_on_k;
	logic         single_k;
	logic         rd_pend_reg;
	logic         wr_pend_reg;
	dps_wr_word_t wr_first_reg;
	dps_burst_t   rd_burst_reg;
	dps_wr_word_t wr_second;

	dps_sync2 #(.RESET_VAL(1'b1)) u_sync_rst_k (
		.clk_in (k_clk_in),
		.rst_in (rst_in),
		.d_in   (1'b0),
		.q_out  (rst_k)
	);

	dps_sync2 #(.RESET_VAL(1'b0)) u_sync_pll_k (
		.clk_in (k_clk_in),
		.rst_in (rst_in),
		.d_in   (pll_off_n_in),
		.q_out  (pll_on_k)
	);

	dps_sync2 #(.RESET_VAL(1'b0)) u_sync_single_k (
		.clk_in (k_clk_in),
		.rst_in (rst_in),
		.d_in   (single_sys_reg),
		.q_out  (single_k)
	);

	// Selects sampled on positive rises only
	always_ff @(posedge k_clk_in or posedge rst_k) begin
		if (rst_k) begin
			rd_pend_reg  <= 1'b0; // see [RULE_20]
			wr_pend_reg  <= 1'b0;
			wr_first_reg <= '{data: WORD_ZERO, bws_n: BWS_NONE};
		end else begin
			rd_pend_reg  <= ~read_port_select_n_in;  // see [RULE_03], [RULE_06], [RULE_15]
			wr_pend_reg  <= ~write_port_select_n_in; // see [RULE_09], [RULE_15]
			wr_first_reg <= '{data: d_in, bws_n: byte_write_select_n_in}; // see [RULE_04]
		end
	end

	// Read address taken at the select edge; both burst words fetched together.
	// A write begun one rise earlier committed at the negative rise between, so
	// this read already sees it.
	always_ff @(posedge k_clk_in) begin
		if (!read_port_select_n_in) begin
			rd_burst_reg.w0 <= {mem_lo_b1[addr_in], mem_lo_b0[addr_in]}; // see [RULE_06], [RULE_14]
			rd_burst_reg.w1 <= {mem_hi_b1[addr_in], mem_hi_b0[addr_in]}; // see [RULE_01]
		end
	end

	// Negative input clock rise modelled as the falling edge of the positive clock
	assign wr_second = '{data: d_in, bws_n: byte_write_select_n_in};

	// Pending write commits whatever the select does now
	always_ff @(negedge k_clk_in) begin
		if (wr_pend_reg) begin // see [RULE_12], [RULE_10]
			if (!wr_first_reg.bws_n[0]) begin
				mem_lo_b0[addr_in] <= wr_first_reg.data[BYTE_W-1:0]; // see [RULE_11]
			end
			if (!wr_first_reg.bws_n[1]) begin
				mem_lo_b1[addr_in] <= wr_first_reg.data[WORD_W-1:BYTE_W];
			end
			if (!wr_second.bws_n[0]) begin
				mem_hi_b0[addr_in] <= wr_second.data[BYTE_W-1:0]; // see [RULE_04], [RULE_11]
			end
			if (!wr_second.bws_n[1]) begin
				mem_hi_b1[addr_in] <= wr_second.data[WORD_W-1:BYTE_W];
			end
		end
	end

	// Output clock domain; C is assumed skew-matched to K so no crossing is used
	logic              out_clk;
	logic              a1_pend_reg;
	dps_burst_t        a1_burst_reg;
	logic [WORD_W-1:0] p_data_reg;
	logic              p_oe_reg;
	logic [WORD_W-1:0] n_data_reg;
	logic              n_oe_reg;
	logic              p_load;
	logic [WORD_W-1:0] p_word;
	logic [WORD_W-1:0] n_word;

	// In single mode C is tied high, so the strap picks K as output timing
	assign out_clk = single_k ? k_clk_in : c_clk_in; // see [RULE_05], [RULE_13]

	assign p_load = pll_on_k ? a1_pend_reg : rd_pend_reg;                  // see [RULE_02]
	assign p_word = pll_on_k ? a1_burst_reg.w1 : rd_burst_reg.w0;          // see [RULE_07]
	assign n_word = pll_on_k ? a1_burst_reg.w0 : a1_burst_reg.w1;

	always_ff @(posedge out_clk or posedge rst_k) begin
		if (rst_k) begin
			a1_pend_reg  <= 1'b0;
			a1_burst_reg <= '{w1: WORD_ZERO, w0: WORD_ZERO};
			p_data_reg   <= WORD_ZERO;
			p_oe_reg     <= 1'b0; // see [RULE_20]
		end else begin
			a1_pend_reg  <= rd_pend_reg;
			a1_burst_reg <= rd_burst_reg;
			p_data_reg   <= p_word;
			p_oe_reg     <= p_load; // see [RULE_05], [RULE_08]
		end
	end

	always_ff @(negedge out_clk or posedge rst_k) begin
		if (rst_k) begin
			n_data_reg <= WORD_ZERO;
			n_oe_reg   <= 1'b0;
		end else begin
			n_data_reg <= n_word;      // see [RULE_07]
			n_oe_reg   <= a1_pend_reg; // see [RULE_02], [RULE_08]
		end
	end

	// Double-rate output needs a clock-phase select after the two launch flops
	assign q_out    = out_clk ? p_data_reg : n_data_reg;
	assign q_oe_out = out_clk ? p_oe_reg : n_oe_reg;

	// Echo clocks run free whether or not reads are in flight
	assign echo_clock_out   = out_clk;  // see [RULE_17]
	assign echo_clock_n_out = ~out_clk;
endmodule : dps_sram_top

/* verif/dps_sram_chk.sv */
// Port assertions for the burst memory top
module dps_sram_chk
	import dps_pkg::*;
(
	input  wire logic clk_sys_in,
	input  wire logic rst_in,
	input  wire logic k_clk_in,
	input  wire logic c_clk_in,
	input  wire logic read_port_select_n_in,
	input  wire logic q_oe_out,
	input  wire logic echo_clock_out,
	input  wire logic echo_clock_n_out,
	input  wire logic pll_locked_out,
	input  wire logic single_clock_mode_out,
	input  wire logic impedance_update_out
);
	logic [10:0] gap_reg;
	logic        seen_reg;
	// First pulse has no defined offset from reset, so only gaps are checked
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) {seen_reg, gap_reg} <= 12'h000;
		else {seen_reg, gap_reg} <= {seen_reg | impedance_update_out,
			impedance_update_out ? 11'h000 : gap_reg + 11'h001};
	end
	sequence s_rd;
		!read_port_select_n_in;
	endsequence
	property p_oe_rd;
		@(posedge k_clk_in) disable iff (rst_in) s_rd |-> ##2 q_oe_out;
	endproperty
	a_oe_rd: assert property (p_oe_rd) else $error("burst missing");
	property p_oe_tim;
		@(posedge k_clk_in) disable iff (rst_in) q_oe_out == $past(!read_port_select_n_in, 2);
	endproperty
	a_oe_tim: assert property (p_oe_tim) else $error("oe window wrong");
	property p_echo;
		@(posedge clk_sys_in) disable iff (rst_in) echo_clock_n_out == !echo_clock_out &&
			echo_clock_out == (single_clock_mode_out ? k_clk_in : c_clk_in);
	endproperty
	a_echo: assert property (p_echo) else $error("echo clock wrong");
	property p_cal_gap;
		@(posedge clk_sys_in) disable iff (rst_in)
			impedance_update_out && seen_reg |-> gap_reg == CAL_CYCLES - 1;
	endproperty
	a_cal_gap: assert property (p_cal_gap) else $error("cal period wrong");
	property p_cal_one;
		@(posedge clk_sys_in) disable iff (rst_in) impedance_update_out |=> !impedance_update_out;
	endproperty
	a_cal_one: assert property (p_cal_one) else $error("cal pulse long");
	property p_lock_keep;
		@(posedge clk_sys_in) disable iff (rst_in) pll_locked_out |=> pll_locked_out;
	endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("lock lost");
	property p_strap;
		@(posedge clk_sys_in) disable iff (rst_in) single_clock_mode_out |=> single_clock_mode_out;
	endproperty
	a_strap: assert property (p_strap) else $error("strap changed");
	property p_rst;
		@(posedge clk_sys_in) rst_in |-> !q_oe_out && !pll_locked_out && !impedance_update_out;
	endproperty
	a_rst: assert property (p_rst) else $error("not quiet in reset");
endmodule : dps_sram_chk

bind dps_sram_top dps_sram_chk u_chk (.*);

/* verif/dps_ctl_model.sv */
// Controller model: link clocks, port selects, address and write words
module dps_ctl_model
	import dps_pkg::*;
(
	input  wire logic              strap_in,
	input  wire logic              pll_off_n_in,
	input  wire logic [WORD_W-1:0] q_in,
	input  wire logic              q_oe_in,
	output logic                   k_out,
	output logic                   c_out,
	output logic                   c_n_out,
	output logic                   rd_sel_n_out,
	output logic                   wr_sel_n_out,
	output logic [NBYTES-1:0]      be_n_out,
	output logic [ADDR_W-1:0]      addr_out,
	output logic [WORD_W-1:0]      d_out
);
	timeunit 1ns;
	timeprecision 100ps;
	dps_burst_t rq[$];
	logic [1:0] oq[$];
	// Free running; the lock timer counts clk_sys_in and never sees this clock
	initial begin
		k_out = 1'b0;
		#3.3;
		forever #7.5 k_out = ~k_out;
	end
	assign c_out   = strap_in | k_out;
	assign c_n_out = strap_in | ~k_out;
	initial begin
		{rd_sel_n_out, wr_sel_n_out, be_n_out} = 4'hF;
		addr_out = 20'h00000;
		d_out = WORD_ZERO;
	end
	// Second word stays across the fall; the next request replaces it
	task automatic cyc(input logic rd, wr, input logic [ADDR_W-1:0] ar, aw,
			input dps_wr_word_t w0, w1);
		@(negedge k_out) #3;
		{rd_sel_n_out, wr_sel_n_out, addr_out} = {!rd, !wr, ar};
		{d_out, be_n_out} = w0;
		@(posedge k_out) #3;
		{rd_sel_n_out, wr_sel_n_out, addr_out} = {2'h3, aw};
		{d_out, be_n_out} = w1;
	endtask : cyc
	task automatic cap;
		dps_burst_t b;
		logic [2:0] o;
		@(posedge k_out);
		if (pll_off_n_in) @(negedge k_out);
		#3 {b.w0, o[2]} = {q_in, q_oe_in};
		@(k_out) #3 {b.w1, o[1]} = {q_in, q_oe_in};
		@(k_out) #3 o[0] = q_oe_in;
		rq.push_back(b);
		oq.push_back({o[2] & o[1], o[0]});
	endtask : cap
	always @(posedge k_out) if (rd_sel_n_out === 1'b0) fork cap(); join_none
endmodule : dps_ctl_model

/* verif/dps_sram_top_test.sv */
// Bench for the burst memory top with a controller model
module dps_sram_top_test
	import dps_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [ADDR_W-1:0] A1 = 20'h5A3C1, A2 = 20'hA5C3E;
	localparam logic [WORD_W-1:0] P0 = 18'h0AAAA, P1 = 18'h15555, N0 = 18'h3C3C3, N1 = 18'h2D2D2;
	localparam logic [WORD_W-1:0] Q0 = 18'h12345, Q1 = 18'h2ABCD, Z0 = 18'h00F0F, Z1 = 18'h3F0F0;
	logic              clk_sys_in = 1'b0;
	// Left unknown until time zero so the asynchronous reset sees an edge
	logic              rst_in;
	logic              pll_off_n = 1'b1;
	logic              strap = 1'b0;
	logic              k, c, c_n, rd_n, wr_n, q_oe, echo, echo_n, locked, single, upd;
	logic [NBYTES-1:0] be_n;
	logic [ADDR_W-1:0] addr;
	logic [WORD_W-1:0] d, q;
	int                failures = 0;
	int                tests_run = 0;
	initial forever #50 clk_sys_in = ~clk_sys_in;
	dps_sram_top DUT (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .k_clk_in(k), .c_clk_in(c),
		.c_n_clk_in(c_n), .pll_off_n_in(pll_off_n), .read_port_select_n_in(rd_n),
		.write_port_select_n_in(wr_n), .byte_write_select_n_in(be_n), .addr_in(addr),
		.d_in(d), .q_out(q), .q_oe_out(q_oe), .echo_clock_out(echo), .echo_clock_n_out(echo_n),
		.pll_locked_out(locked), .single_clock_mode_out(single), .impedance_update_out(upd));
	dps_ctl_model model (
		.strap_in(strap), .pll_off_n_in(pll_off_n), .q_in(q), .q_oe_in(q_oe), .k_out(k),
		.c_out(c), .c_n_out(c_n), .rd_sel_n_out(rd_n), .wr_sel_n_out(wr_n), .be_n_out(be_n),
		.addr_out(addr), .d_out(d));
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : summarize
	task automatic cmp(input logic [35:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask : cmp
	task automatic reset(input logic pll, st);
		@(negedge clk_sys_in);
		{rst_in, pll_off_n, strap} = {1'b1, pll, st};
		repeat (4) @(negedge clk_sys_in);
		cmp(36'({q_oe, locked, single, upd}), 36'h0);
		rst_in = 1'b0;
	endtask : reset
	// Latency is judged by the model's fixed capture points
	task automatic rd_chk(input dps_burst_t e, input logic [1:0] eo);
		repeat (12) @(posedge k);
		if (model.rq.size() == 0) begin
			failures++;
			$display("mismatch at %0t: read burst not captured", $time);
			summarize();
		end
		cmp(model.rq.pop_front(), e);
		cmp(36'(model.oq.pop_front()), 36'(eo));
	endtask : rd_chk
	task automatic t_lock;
		int n;
		for (n = 0; n < 400 && locked !== 1'b1; n++) @(negedge clk_sys_in);
		cmp(36'(n >= LOCK_CYCLES - 1 && n <= LOCK_CYCLES + 1), 36'h1);
	endtask : t_lock
	task automatic t_cal;
		int n;
		for (n = 0; n < 1100 && upd !== 1'b1; n++) @(negedge clk_sys_in);
		@(negedge clk_sys_in);
		for (n = 1; n < 1100 && upd !== 1'b1; n++) @(negedge clk_sys_in);
		cmp(36'(n), 36'(CAL_CYCLES));
	endtask : t_cal
	task automatic t_mem;
		model.cyc(1'b0, 1'b1, A1, A2, {Z0, 2'h0}, {Z1, 2'h0});
		model.cyc(1'b0, 1'b1, A1, A1, {P0, 2'h0}, {P1, 2'h0});
		model.cyc(1'b0, 1'b1, A1, A1, {N0, 2'h2}, {N1, 2'h1});
		model.cyc(1'b1, 1'b1, A1, A1, {Q0, 2'h0}, {Q1, 2'h0});
		model.cyc(1'b1, 1'b1, A1, A2, {P1, 2'h3}, {P0, 2'h3});
		model.cyc(1'b1, 1'b0, A2, A2, {N1, 2'h0}, {N0, 2'h0});
		model.cyc(1'b0, 1'b0, ~A2, ~A1, {~N1, 2'h0}, {~N0, 2'h0});
		rd_chk({N1[17:9], P1[8:0], P0[17:9], N0[8:0]}, 2'h3);
		rd_chk({Q1, Q0}, 2'h3);
		rd_chk({Z1, Z0}, 2'h2);
	endtask : t_mem
	task automatic t_mode(input logic pll, st, input logic [ADDR_W-1:0] a, input dps_burst_t e);
		reset(pll, st);
		repeat (20) @(negedge clk_sys_in);
		cmp(36'(single), 36'(st));
		model.cyc(1'b1, 1'b0, a, ~a, {~e.w0, 2'h3}, {~e.w1, 2'h3});
		model.cyc(1'b0, 1'b0, ~a, a, {e.w0, 2'h3}, {e.w1, 2'h3});
		rd_chk(e, 2'h2);
	endtask : t_mode
	initial begin
		rst_in = 1'b1;
		reset(1'b1, 1'b0);
		t_lock();
		t_cal();
		t_mem();
		t_mode(1'b0, 1'b0, A1, {Q1, Q0});
		t_mode(1'b1, 1'b1, A2, {Z1, Z0});
		summarize();
	end
endmodule : dps_sram_top_test
